// File: rtl/ci_write_and_aux_select.sv
// Host write sequencer for two module slots and the auxiliary peripheral
// Contract
// - Hold output is wait or acknowledge, configurable
// - Pick chip enable by slot, mode, target
// - Register select idle for common and aux writes
// - Write strobe for memory, IO strobe otherwise
// - Module wait freezes the strobe counter
// - Memory grades share one write timing table
// - Detect start, then assert chip enable
// - Strobe follows cycle start by grade minimum
// - Strobe follows chip enable by 2 or 1
// - Strobe width set per speed grade
// - Recover then release enables, signal acknowledge
// - Data buffers enabled before the write strobe
// - Aux select: open-drain or push-pull, polarity
// - Fallback or pattern match selects aux
// - Manual pick 11 selects the aux
// - Aux select transmit or regenerate mode
// - Transmit mode follows host chip select
// - Regenerate mode driven like a chip enable
// - Aux interrupt routed with selectable polarity
// - Aux interrupt mask blocks the host interrupt
// - Aux interrupt level readable as status
// - Access kind picks strobes and enables
`timescale 1ns/1ps
module ci_write_and_aux_select (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic host_cs_i, // Host chip select, active high
  input wire logic host_wr_i, // Host write request, active high
  input wire logic [ci_write_pkg::ADDR_W-1:0] host_addr_i,
  input wire logic slot_a_wait_n_i,
  input wire logic slot_b_wait_n_i,
  input wire logic hold_as_ack_i, // 0 wait style, 1 acknowledge style
  input wire logic hold_active_high_i,
  input wire logic hold_open_drain_i,
  input wire logic [1:0] access_kind_a_i,
  input wire logic [1:0] access_kind_b_i,
  input wire logic [2:0] grade_a_i,
  input wire logic [2:0] grade_b_i,
  input wire logic [ci_write_pkg::ADDR_W-1:0] mask_a_i,
  input wire logic [ci_write_pkg::ADDR_W-1:0] pattern_a_i,
  input wire logic [ci_write_pkg::ADDR_W-1:0] mask_b_i,
  input wire logic [ci_write_pkg::ADDR_W-1:0] pattern_b_i,
  input wire logic [ci_write_pkg::ADDR_W-1:0] mask_aux_i,
  input wire logic [ci_write_pkg::ADDR_W-1:0] pattern_aux_i,
  input wire logic auto_target_bit_i,
  input wire logic [1:0] target_pick_field_i,
  input wire logic fallback_target_bit_i,
  input wire logic aux_select_style_bit_i, // 0 transmit, 1 regenerate
  input wire logic aux_cs_active_high_i,
  input wire logic aux_cs_open_drain_i,
  input wire logic aux_irq_in_i,
  input wire logic aux_irq_polarity_bit_i, // 1 active high
  input wire logic aux_irq_mask_bit_i, // 1 masks
  output logic slot_a_enable_low_o,
  output logic slot_b_enable_low_o,
  output logic slot_a_channel_enable_o, // Active low
  output logic slot_b_channel_enable_o, // Active low
  output logic reg_select_n_o,
  output logic write_strobe_n_o,
  output logic io_write_n_o,
  output logic data_enable_n_o,
  output logic hold_o,
  output logic hold_oe_n_o,
  output logic aux_chip_select_o,
  output logic aux_cs_oe_n_o,
  output logic host_irq_out_o,
  output logic aux_irq_status_bit_o
);

  // ************************************************************
  // Target decode
  // ************************************************************
  // Masked address compare shared by both slots and the aux
  function automatic logic addr_hit(
    input logic [ci_write_pkg::ADDR_W-1:0] a,
    input logic [ci_write_pkg::ADDR_W-1:0] m,
    input logic [ci_write_pkg::ADDR_W-1:0] p
  );
    addr_hit = ((a ^ p) & m) == '0;
  endfunction : addr_hit
  ci_write_pkg::pick_t pick_now; // Target of the current host address

  // Manual or automatic selection of the destination
  always_comb begin
    if (!auto_target_bit_i) begin
      pick_now = ci_write_pkg::pick_t'(target_pick_field_i);
    end else if (addr_hit(host_addr_i, mask_a_i, pattern_a_i)) begin
      pick_now = ci_write_pkg::PICK_A;
    end else if (addr_hit(host_addr_i, mask_b_i, pattern_b_i)) begin
      pick_now = ci_write_pkg::PICK_B;
    end else if (fallback_target_bit_i) begin
      pick_now = ci_write_pkg::PICK_AUX;
    end else if (addr_hit(host_addr_i, mask_aux_i, pattern_aux_i)) begin
      pick_now = ci_write_pkg::PICK_AUX;
    end else begin
      pick_now = ci_write_pkg::PICK_NONE;
    end
  end

  // ************************************************************
  // Latched cycle attributes
  // ************************************************************
  ci_write_pkg::state_t state; // Sequencer state
  ci_write_pkg::state_t next_state;
  ci_write_pkg::pick_t pick; // Target of the running cycle
  ci_write_pkg::kind_t kind; // Access kind of the running cycle
  ci_write_pkg::grade_t grade; // Speed grade of the running cycle
  logic start; // New host write seen
  logic phase_done; // Current phase elapsed
  logic load; // Phase timer reload
  logic [ci_write_pkg::CNT_W-1:0] load_val;
  logic freeze; // Module wait request
  logic slow; // 600 ns or IO grade
  assign start = host_cs_i && host_wr_i && (pick_now != ci_write_pkg::PICK_NONE);
  assign slow = (grade == ci_write_pkg::GRADE_600) || (grade == ci_write_pkg::GRADE_IO);

  // Capture target, kind and grade at cycle start
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pick <= ci_write_pkg::PICK_NONE;
      kind <= ci_write_pkg::KIND_ATTR;
      grade <= ci_write_pkg::GRADE_600;
    end else if (state == ci_write_pkg::ST_IDLE && start) begin
      pick <= pick_now;
      if (pick_now == ci_write_pkg::PICK_AUX) begin
        kind <= ci_write_pkg::KIND_IO; // Aux uses IO strobes
        grade <= ci_write_pkg::GRADE_IO;
      end else if (pick_now == ci_write_pkg::PICK_A) begin
        kind <= ci_write_pkg::kind_t'(access_kind_a_i);
        grade <= (access_kind_a_i[1]) ? ci_write_pkg::GRADE_IO
                                      : ci_write_pkg::grade_t'(grade_a_i);
      end else begin
        kind <= ci_write_pkg::kind_t'(access_kind_b_i);
        grade <= (access_kind_b_i[1]) ? ci_write_pkg::GRADE_IO
                                      : ci_write_pkg::grade_t'(grade_b_i);
      end
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  // Module wait stops the strobe count; aux has no wait line
  always_comb begin
    freeze = 1'b0;
    if (state == ci_write_pkg::ST_STROBE) begin
      if (pick == ci_write_pkg::PICK_A) begin
        freeze = !slot_a_wait_n_i;
      end else if (pick == ci_write_pkg::PICK_B) begin
        freeze = !slot_b_wait_n_i;
      end
    end
  end

  // Next state and phase timer reload
  always_comb begin
    next_state = state;
    load = 1'b0;
    load_val = '0;
    case (state)
      ci_write_pkg::ST_IDLE: begin
        if (start) begin
          next_state = ci_write_pkg::ST_DETECT;
        end
      end
      ci_write_pkg::ST_DETECT: begin
        next_state = ci_write_pkg::ST_SETUP;
        load = 1'b1;
        load_val = (slow ? ci_write_pkg::T3_SLOW : ci_write_pkg::T3_FAST)
                   - ci_write_pkg::CNT_ONE;
      end
      ci_write_pkg::ST_SETUP: begin
        if (phase_done) begin
          next_state = ci_write_pkg::ST_STROBE;
          load = 1'b1;
          load_val = ci_write_pkg::strobe_len(grade) - ci_write_pkg::CNT_ONE;
        end
      end
      ci_write_pkg::ST_STROBE: begin
        if (phase_done) begin
          next_state = ci_write_pkg::ST_RECOVER;
          load = 1'b1;
          load_val = ((grade == ci_write_pkg::GRADE_600) ? ci_write_pkg::T5_SLOW
                      : ci_write_pkg::T5_FAST) - ci_write_pkg::CNT_ONE;
        end
      end
      ci_write_pkg::ST_RECOVER: begin
        if (phase_done) begin
          next_state = ci_write_pkg::ST_FINISH;
        end
      end
      ci_write_pkg::ST_FINISH: begin
        // The host keeps its write up until released
        if (!host_wr_i || !host_cs_i) begin
          next_state = ci_write_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = ci_write_pkg::ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= ci_write_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Phase length counter
  ci_phase_timer #(
    .CNT_W(ci_write_pkg::CNT_W)
  ) u_timer (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .load_i(load),
    .load_val_i(load_val),
    .freeze_i(freeze),
    .done_o(phase_done)
  );

  // ************************************************************
  // Module side outputs
  // ************************************************************
  logic next_ce; // Chip enable phase
  logic next_wr; // Strobe phase
  logic is_mem; // Memory kind
  assign next_ce = (next_state == ci_write_pkg::ST_SETUP)
                || (next_state == ci_write_pkg::ST_STROBE)
                || (next_state == ci_write_pkg::ST_RECOVER);
  assign next_wr = (next_state == ci_write_pkg::ST_STROBE);
  assign is_mem = !kind[1];

  // Enables, register select and strobes, all registered
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      slot_a_enable_low_o <= 1'b1;
      slot_b_enable_low_o <= 1'b1;
      slot_a_channel_enable_o <= 1'b1;
      slot_b_channel_enable_o <= 1'b1;
      reg_select_n_o <= 1'b1;
      write_strobe_n_o <= 1'b1;
      io_write_n_o <= 1'b1;
      data_enable_n_o <= 1'b1;
    end else begin
      // Side channel uses the channel enable, other kinds the main one
      slot_a_enable_low_o <= !(next_ce && pick == ci_write_pkg::PICK_A
                               && kind != ci_write_pkg::KIND_SIDE);
      slot_b_enable_low_o <= !(next_ce && pick == ci_write_pkg::PICK_B
                               && kind != ci_write_pkg::KIND_SIDE);
      slot_a_channel_enable_o <= !(next_ce && pick == ci_write_pkg::PICK_A
                                   && kind == ci_write_pkg::KIND_SIDE);
      slot_b_channel_enable_o <= !(next_ce && pick == ci_write_pkg::PICK_B
                                   && kind == ci_write_pkg::KIND_SIDE);
      // Register space for attribute, IO and side channel on a slot
      reg_select_n_o <= !(next_ce && pick != ci_write_pkg::PICK_AUX
                          && kind != ci_write_pkg::KIND_COMMON);
      write_strobe_n_o <= !(next_wr && is_mem);
      io_write_n_o <= !(next_wr && !is_mem);
      // Buffers open with chip enable, ahead of the strobe
      data_enable_n_o <= !next_ce;
    end
  end

  // ************************************************************
  // Host hold output
  // ************************************************************
  logic next_busy; // Host must stall
  logic next_hold_act; // Logical hold or acknowledge
  assign next_busy = (next_state != ci_write_pkg::ST_IDLE)
                  && (next_state != ci_write_pkg::ST_FINISH);
  assign next_hold_act = hold_as_ack_i ? (next_state == ci_write_pkg::ST_FINISH)
                                       : next_busy;

  // Level and driver style of the hold pin
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hold_o <= 1'b1;
      hold_oe_n_o <= 1'b1;
    end else begin
      hold_o <= next_hold_act ~^ hold_active_high_i;
      // Open drain only pulls low
      hold_oe_n_o <= hold_open_drain_i
                     && !(next_hold_act && !hold_active_high_i);
    end
  end

  // ************************************************************
  // Auxiliary chip select
  // ************************************************************
  logic next_aux_act; // Logical aux select
  assign next_aux_act = aux_select_style_bit_i
    ? (next_ce && pick == ci_write_pkg::PICK_AUX)
    : (host_cs_i && pick_now == ci_write_pkg::PICK_AUX);

  // Polarity and driver style under software control
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aux_chip_select_o <= 1'b1;
      aux_cs_oe_n_o <= 1'b1;
    end else begin
      aux_chip_select_o <= next_aux_act ~^ aux_cs_active_high_i;
      aux_cs_oe_n_o <= aux_cs_open_drain_i
                       && !(next_aux_act && !aux_cs_active_high_i);
    end
  end

  // ************************************************************
  // Auxiliary interrupt
  // ************************************************************
  logic irq_act; // Input in its active state
  assign irq_act = aux_irq_in_i ~^ aux_irq_polarity_bit_i;

  // Status follows the input, host line gated by the mask
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aux_irq_status_bit_o <= 1'b0;
      host_irq_out_o <= 1'b0;
    end else begin
      aux_irq_status_bit_o <= irq_act;
      host_irq_out_o <= irq_act && !aux_irq_mask_bit_i;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_common_no_reg: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (kind == ci_write_pkg::KIND_COMMON || pick == ci_write_pkg::PICK_AUX)
    && state != ci_write_pkg::ST_IDLE |-> reg_select_n_o)
    else $error("register select active on common or aux write");
  a_strobe_kind: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    !write_strobe_n_o |-> is_mem && io_write_n_o)
    else $error("memory strobe on non memory write");
  a_wait_freeze: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    state == ci_write_pkg::ST_STROBE && freeze |=> state == ci_write_pkg::ST_STROBE)
    else $error("strobe ended during module wait");
  a_ce_after_start: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    state == ci_write_pkg::ST_IDLE && start |=> ##1 !data_enable_n_o)
    else $error("chip enable not two cycles after start");
  a_fast_setup: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    $fell(data_enable_n_o) && !slow |=> state == ci_write_pkg::ST_STROBE)
    else $error("fast grade strobe not one cycle after enable");
  a_slow_setup: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    $fell(data_enable_n_o) && slow |=> state == ci_write_pkg::ST_SETUP
    ##1 state == ci_write_pkg::ST_STROBE)
    else $error("slow grade strobe not two cycles after enable");
  a_strobe_100: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    $rose(state == ci_write_pkg::ST_STROBE) && grade == ci_write_pkg::GRADE_100
    && !freeze ##1 !freeze |=> state == ci_write_pkg::ST_RECOVER)
    else $error("100 ns strobe width wrong");
  a_hold_release: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    state == ci_write_pkg::ST_RECOVER && phase_done && !hold_as_ack_i
    |=> hold_o == !hold_active_high_i && data_enable_n_o)
    else $error("hold not released at write end");
  a_irq_mask: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    aux_irq_mask_bit_i |=> !host_irq_out_o)
    else $error("masked aux interrupt reached host");

endmodule : ci_write_and_aux_select

// File: rtl/ci_write_pkg.sv
// Constants, encodings and timing tables for the host write sequencer
package ci_write_pkg;

  // ************************************************************
  // Clock and host cycle detection
  // ************************************************************
  localparam int CLK_PERIOD_PS = 25000; // 40 MHz clock
  localparam int DETECT_PS = 37500; // 1.5 cycle start detection
  localparam int DETECT_CYCLES = (DETECT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int ADDR_W = 11; // Host address bits 25..15
  localparam int CNT_W = 4; // Phase counter width

  // ************************************************************
  // Speed grades and access kinds
  // ************************************************************
  typedef enum logic [2:0] {
    GRADE_600 = 3'h0,
    GRADE_250 = 3'h1,
    GRADE_200 = 3'h2,
    GRADE_150 = 3'h3,
    GRADE_100 = 3'h4,
    GRADE_IO = 3'h5
  } grade_t;

  typedef enum logic [1:0] {
    KIND_ATTR = 2'h0, // Attribute memory
    KIND_COMMON = 2'h1, // Common memory
    KIND_IO = 2'h2, // IO space
    KIND_SIDE = 2'h3 // Side channel
  } kind_t;

  typedef enum logic [1:0] {
    PICK_A = 2'h0,
    PICK_B = 2'h1,
    PICK_NONE = 2'h2,
    PICK_AUX = 2'h3
  } pick_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DETECT = 3'h1,
    ST_SETUP = 3'h2,
    ST_STROBE = 3'h3,
    ST_RECOVER = 3'h4,
    ST_FINISH = 3'h5
  } state_t;

  // ************************************************************
  // Phase lengths in clock cycles
  // ************************************************************
  localparam logic [CNT_W-1:0] T3_SLOW = 4'h2; // CE to strobe, slow grades
  localparam logic [CNT_W-1:0] T3_FAST = 4'h1;
  localparam logic [CNT_W-1:0] T4_600 = 4'h9; // Strobe width
  localparam logic [CNT_W-1:0] T4_250 = 4'h5;
  localparam logic [CNT_W-1:0] T4_200 = 4'h4;
  localparam logic [CNT_W-1:0] T4_150 = 4'h3;
  localparam logic [CNT_W-1:0] T4_100 = 4'h2;
  localparam logic [CNT_W-1:0] T4_IO = 4'h5;
  localparam logic [CNT_W-1:0] T5_SLOW = 4'h2; // Strobe end to release
  localparam logic [CNT_W-1:0] T5_FAST = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

  // Strobe width for a grade
  function automatic logic [CNT_W-1:0] strobe_len(input grade_t g);
    case (g)
      GRADE_600: strobe_len = T4_600;
      GRADE_250: strobe_len = T4_250;
      GRADE_200: strobe_len = T4_200;
      GRADE_150: strobe_len = T4_150;
      GRADE_100: strobe_len = T4_100;
      default: strobe_len = T4_IO;
    endcase
  endfunction : strobe_len

endpackage : ci_write_pkg

// File: rtl/ci_phase_timer.sv
// Down counter timing one phase of the write cycle, with freeze
`timescale 1ns/1ps
module ci_phase_timer #(
  parameter int CNT_W = 4
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic load_i,
  input wire logic [CNT_W-1:0] load_val_i,
  input wire logic freeze_i,
  output logic done_o
);

  // ************************************************************
  // Counter
  // ************************************************************
  logic [CNT_W-1:0] count; // Cycles left in the phase

  // Load on phase entry, count down unless frozen
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count <= '0;
    end else if (load_i) begin
      count <= load_val_i;
    end else if (!freeze_i && count != '0) begin
      count <= count - 1'b1;
    end
  end

  // Phase over once the count is spent and no freeze holds it
  assign done_o = (count == '0) && !freeze_i;

endmodule : ci_phase_timer

// File: verification/ci_slot_model.sv
// Behavioural module slot that answers write strobes with wait requests
`timescale 1ns/1ps
// ************************************************************
// Slot model
// ************************************************************
module ci_slot_model (
  input wire logic clock_i,
  input wire logic ce_n_i, // Any chip enable of this slot, active low
  input wire logic strobe_n_i, // Any write strobe, active low
  input wire logic [3:0] stall_i, // Wait cycles to request per write
  output logic wait_n_o
);
  logic [3:0] count; // Wait cycles already requested
  initial begin
    wait_n_o = 1'b1;
    count = 4'h0;
  end
  // Stall once the strobe is seen, then let the line pull up again
  always @(posedge clock_i) begin
    if (ce_n_i | strobe_n_i) begin
      count <= 4'h0;
      wait_n_o <= 1'b1;
    end else if (count < stall_i) begin
      count <= count + 4'h1;
      wait_n_o <= 1'b0;
    end else begin
      wait_n_o <= 1'b1;
    end
  end
endmodule : ci_slot_model

// File: verification/testbench.sv
// Self-checking testbench for the host write sequencer
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %0t: got %0h expected %0h", $time, g, e); end end
// ************************************************************
// Testbench
// ************************************************************
module testbench;
  logic clock_i = 1'b0, reset_n_i = 1'b0, host_cs_i = 1'b0, host_wr_i = 1'b0;
  logic [10:0] host_addr_i = 11'h000, pat_aux = 11'h100; // Aux match pattern
  logic hold_as_ack_i = 1'b0, hold_active_high_i = 1'b0, auto_i = 1'b1, fallback_i = 1'b0;
  logic [1:0] kind_a = 2'h1, kind_b = 2'h1, pick = 2'h0;
  logic [2:0] grade_a = 3'h1, grade_b = 3'h1;
  logic style_i = 1'b0, cs_high_i = 1'b0, cs_od_i = 1'b0, hold_od = 1'b0;
  logic irq_in = 1'b0, irq_pol = 1'b1, irq_mask = 1'b0;
  logic [3:0] stall = 4'h0; // Wait cycles the slots request
  logic wait_a_n, wait_b_n, en_a, en_b, ch_a, ch_b, reg_n, we_n, iow_n, de_n;
  logic hold_o, hold_oe_n, aux_cs, aux_oe_n, irq_out, irq_stat;
  int fail_count = 0, checked = 0;
  // Clock at 40 MHz
  initial begin
    forever #12.5 clock_i = ~clock_i;
  end
  ci_write_and_aux_select i_dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .host_cs_i(host_cs_i), .host_wr_i(host_wr_i), .host_addr_i(host_addr_i),
    .slot_a_wait_n_i(wait_a_n), .slot_b_wait_n_i(wait_b_n), .hold_as_ack_i(hold_as_ack_i),
    .hold_active_high_i(hold_active_high_i), .hold_open_drain_i(hold_od),
    .access_kind_a_i(kind_a), .access_kind_b_i(kind_b), .grade_a_i(grade_a),
    .grade_b_i(grade_b), .mask_a_i(11'h7ff), .pattern_a_i(11'h000), .mask_b_i(11'h7ff),
    .pattern_b_i(11'h001), .mask_aux_i(11'h7ff), .pattern_aux_i(pat_aux),
    .auto_target_bit_i(auto_i), .target_pick_field_i(pick), .fallback_target_bit_i(fallback_i),
    .aux_select_style_bit_i(style_i), .aux_cs_active_high_i(cs_high_i),
    .aux_cs_open_drain_i(cs_od_i), .aux_irq_in_i(irq_in), .aux_irq_polarity_bit_i(irq_pol),
    .aux_irq_mask_bit_i(irq_mask), .slot_a_enable_low_o(en_a), .slot_b_enable_low_o(en_b),
    .slot_a_channel_enable_o(ch_a), .slot_b_channel_enable_o(ch_b), .reg_select_n_o(reg_n),
    .write_strobe_n_o(we_n), .io_write_n_o(iow_n), .data_enable_n_o(de_n), .hold_o(hold_o),
    .hold_oe_n_o(hold_oe_n), .aux_chip_select_o(aux_cs), .aux_cs_oe_n_o(aux_oe_n),
    .host_irq_out_o(irq_out), .aux_irq_status_bit_o(irq_stat));
  ci_slot_model i_slot_a (.clock_i(clock_i), .ce_n_i(en_a & ch_a), .strobe_n_i(we_n & iow_n),
    .stall_i(stall), .wait_n_o(wait_a_n));
  ci_slot_model i_slot_b (.clock_i(clock_i), .ce_n_i(en_b & ch_b), .strobe_n_i(we_n & iow_n),
    .stall_i(stall), .wait_n_o(wait_b_n));
  // Prints the counts and the verdict, then stops
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_of_test
  // Chip enable chosen by sel: slot A, slot B, channel A, channel B, aux
  function automatic logic ce_of(input int sel);
    case (sel)
      0: ce_of = en_a;
      1: ce_of = en_b;
      2: ce_of = ch_a;
      3: ce_of = ch_b;
      default: ce_of = aux_cs;
    endcase
  endfunction : ce_of
  // One host write, timing each phase at the falling edges
  task automatic wr(input logic [10:0] a, input int sel, io, t3, t4, t5, input logic rg);
    int k, ce_at, s_at, s_end, r_at;
    logic stb;
    ce_at = -1;
    s_at = -1;
    s_end = -1;
    r_at = -1;
    host_addr_i = a;
    host_cs_i = 1'b1;
    host_wr_i = 1'b1;
    for (k = 1; k < 80 && r_at < 0; k++) begin
      @(negedge clock_i);
      stb = io ? iow_n : we_n;
      if (ce_at < 0 && ce_of(sel) === 1'b0) begin
        ce_at = k;
        `CHK(ce_at, ci_write_pkg::DETECT_CYCLES)
        `CHK(reg_n, rg)
        `CHK(de_n, 1'b0)
        `CHK(hold_o, 1'b0)
        `CHK(hold_oe_n, 1'b0)
        `CHK(int'(en_a) + en_b + ch_a + ch_b, (sel < 4) ? 3 : 4)
      end
      if (s_at < 0 && stb === 1'b0) begin
        s_at = k;
        `CHK(io ? we_n : iow_n, 1'b1)
      end
      if (s_at > 0 && s_end < 0 && stb === 1'b1) s_end = k;
      if (s_end > 0 && ce_of(sel) === 1'b1) r_at = k;
    end
    if (r_at < 0) begin
      fail_count++;
      $display("[ERR] %0t: write never completed", $time);
      end_of_test();
    end
    `CHK(s_at - ce_at, t3)
    `CHK(s_end - s_at, t4)
    `CHK(r_at - s_end, t5)
    `CHK(hold_o, 1'b1)
    `CHK(hold_oe_n, hold_od)
    host_cs_i = 1'b0;
    host_wr_i = 1'b0;
    repeat (2) @(negedge clock_i);
    `CHK(hold_o, ~hold_as_ack_i)
  endtask : wr
  // Aux select level for a chip-select-only host access
  task automatic aux_probe(input logic [10:0] a, input logic e, oe);
    host_addr_i = a;
    host_cs_i = 1'b1;
    repeat (2) @(negedge clock_i);
    `CHK(aux_cs, e)
    `CHK(aux_oe_n, oe)
    host_cs_i = 1'b0;
    repeat (2) @(negedge clock_i);
  endtask : aux_probe
  int t4s[5] = '{9, 5, 4, 3, 2};
  initial begin
    repeat (12) @(negedge clock_i);
    `CHK(hold_oe_n, 1'b1)
    reset_n_i = 1'b1;
    @(negedge clock_i);
    wr(11'h000, 0, 0, 1, 5, 1, 1'b1);
    kind_a = 2'h0;
    for (int g = 0; g < 5; g++) begin
      grade_a = g[2:0];
      wr(11'h000, 0, 0, (g == 0) ? 2 : 1, t4s[g], (g == 0) ? 2 : 1, 1'b0);
    end
    kind_b = 2'h2;
    grade_b = 3'h0;
    wr(11'h001, 1, 1, 2, 5, 1, 1'b0);
    kind_b = 2'h3;
    wr(11'h001, 3, 1, 2, 5, 1, 1'b0);
    kind_a = 2'h1;
    grade_a = 3'h1;
    stall = 4'h3;
    hold_od = 1'b1;
    wr(11'h000, 0, 0, 1, 8, 1, 1'b1);
    stall = 4'h0;
    hold_od = 1'b0;
    hold_as_ack_i = 1'b1;
    hold_active_high_i = 1'b1;
    wr(11'h000, 0, 0, 1, 5, 1, 1'b1);
    fallback_i = 1'b1;
    cs_od_i = 1'b1;
    aux_probe(11'h7ff, 1'b0, 1'b0);
    `CHK(aux_oe_n, 1'b1)
    fallback_i = 1'b0;
    cs_od_i = 1'b0;
    cs_high_i = 1'b1;
    aux_probe(11'h100, 1'b1, 1'b0);
    aux_probe(11'h7ff, 1'b0, 1'b0);
    pat_aux = 11'h7ff;
    aux_probe(11'h7ff, 1'b1, 1'b0);
    cs_high_i = 1'b0;
    auto_i = 1'b0;
    pick = 2'h3;
    style_i = 1'b1;
    wr(11'h000, 4, 1, 2, 5, 1, 1'b1);
    for (int i = 0; i < 8; i++) begin
      {irq_pol, irq_mask, irq_in} = i[2:0];
      repeat (2) @(negedge clock_i);
      `CHK(irq_stat, irq_in == irq_pol)
      `CHK(irq_out, (irq_in == irq_pol) & ~irq_mask)
    end
    end_of_test();
  end
endmodule : testbench
